//--- design/pic_pkg.sv
// Constants and carrier types for the prioritized interrupt controller
package pic_pkg;
   // Register byte offsets
   localparam logic [7:0] OFS_FLAGS0 = 8'h00;
   localparam logic [7:0] OFS_ENABLE0 = 8'h0c;
   localparam logic [7:0] OFS_PRIO0 = 8'h20;
   localparam logic [7:0] OFS_EXC_CTRL = 8'h50;
   localparam logic [7:0] OFS_EXT_CTRL = 8'h54;
   localparam logic [7:0] OFS_CPU_LEVEL = 8'h58;
   localparam logic [7:0] OFS_TIMED_INTERRUPT_DISABLE_CNT = 8'h5c;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h60;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h64;
   localparam logic [7:0] OFS_SERVICE = 8'h68;
   // Counts
   localparam int NUM_FLAG_REGS = 3;
   localparam int NUM_PRIO_REGS = 11;
   localparam int NUM_EXT = 3;
   localparam int NUM_TRAPS = 4;
   // Field positions
   localparam int NESTING_DISABLE_BIT = 15;
   localparam int ALT_TABLE_BIT = 15;
   localparam int TIMED_INTERRUPT_DISABLE_BIT = 14;
   localparam int PRIO_FIELD_STRIDE = 4;
   // Levels and vectors
   localparam logic [3:0] TIMED_INTERRUPT_DISABLE_MAX_LEVEL = 4'h6;
   localparam logic [3:0] TRAP_BASE_LEVEL = 4'h8;
   localparam logic [5:0] TRAP_BASE_VECTOR = 6'h01;
   localparam logic [5:0] IRQ_BASE_VECTOR = 6'h08;
   localparam logic [23:0] PRIMARY_TABLE_BASE = 24'h000004;
   localparam logic [23:0] ALTERNATE_TABLE_BASE = 24'h000084;
   localparam logic [23:0] VECTOR_SPACE_END = 24'h0000fe;
   // Reset values
   localparam logic [3:0] CPU_LEVEL_RESET = 4'h0;
   localparam logic [15:0] IRQ_MASK_RESET = 16'h0000;
   // Block interrupt status bits
   localparam int EVT_TAKEN = 0;
   localparam int EVT_ADDR_ERR = 1;
   localparam int EVT_TIMED_INTERRUPT_DISABLE_END = 2;
   localparam int NUM_EVT = 3;

   typedef struct packed {
      logic valid;
      logic [5:0] vector;
      logic [3:0] level;
   } pic_req_s;

   typedef struct packed {
      logic [4:0] flags;
      logic [15:0] w3;
      logic [15:0] w2;
      logic [15:0] w1;
      logic [15:0] w0;
   } pic_shadow_s;
endpackage : pic_pkg

//--- design/pic_top.sv
// Prioritized interrupt controller with AHB-Lite register slave
`timescale 1ns/100ps
`default_nettype none

module pic_top #(
   parameter int NUM_SRC = 41
) (
   // Clock and reset
   input wire logic CLK_SYS,
   input wire logic RESET_N,
   // AHB-Lite slave
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic [31:0] HRDATA,
   output logic HREADYOUT,
   output logic HRESP,
   output logic IRQ,
   // Request sources
   input wire logic [pic_pkg::NUM_EXT-1:0] EXT_REQ,
   input wire logic [NUM_SRC-pic_pkg::NUM_EXT-1:0] PERIPH_REQ,
   input wire logic [pic_pkg::NUM_TRAPS-1:0] TRAP_REQ,
   // Core request and service
   output pic_pkg::pic_req_s CORE_REQ,
   input wire logic INT_ACK,
   input wire logic INT_RET,
   input wire logic [3:0] RET_LEVEL,
   output logic [3:0] CPU_LEVEL,
   // Timed disable
   input wire logic TIMED_INTERRUPT_DISABLE_START,
   input wire logic [13:0] TIMED_INTERRUPT_DISABLE_COUNT,
   input wire logic INSTR_DONE,
   // Vector fetch and program counter
   output logic VEC_FETCH,
   output logic [23:0] VEC_ADDR,
   input wire logic PDATA_VALID,
   input wire logic [23:0] PDATA,
   input wire logic [23:0] PC_SEQ,
   output logic PC_LOAD,
   output logic [23:0] PC_VALUE,
   input wire logic FETCH_VALID,
   input wire logic FETCH_VECTOR,
   input wire logic [23:0] FETCH_ADDR,
   // Power state
   input wire logic SLEEP_OR_IDLE,
   output logic WAKE,
   // Shadow registers
   input wire logic SHADOW_PUSH,
   input wire logic SHADOW_POP,
   input wire pic_pkg::pic_shadow_s SHADOW_IN,
   output pic_pkg::pic_shadow_s SHADOW_OUT
);
   localparam int FW = 16 * pic_pkg::NUM_FLAG_REGS;

   logic [FW-1:0] flags_reg;
   logic [FW-1:0] enables_reg;
   logic [2:0] prio_reg [NUM_SRC];
   logic [pic_pkg::NUM_TRAPS-1:0] trap_reg;
   logic nesting_disable_reg;
   logic alt_reg;
   logic [pic_pkg::NUM_EXT-1:0] pol_reg;
   logic [pic_pkg::NUM_EXT-1:0] ext_prev_reg;
   logic [3:0] ipl_reg;
   logic [13:0] timed_interrupt_disable_reg;
   logic [7:0] depth_reg;
   logic [15:0] stat_reg;
   logic [15:0] mask_reg;
   logic fetch_wait_reg;

   // Bus capture
   logic wr_pend_reg;
   logic [7:0] wr_addr_reg;
   logic addr_ok;
   logic rd_ok;
   logic wr_en;
   logic [15:0] wd;
   logic [15:0] rd_val;

   assign addr_ok = HSEL && HREADY && HTRANS[1];
   assign rd_ok = addr_ok && !HWRITE;
   assign wr_en = wr_pend_reg;
   assign wd = HWDATA[15:0];

   always_ff @(posedge CLK_SYS or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= 8'h00;
         HREADYOUT <= 1'b1;
         HRESP <= 1'b0;
         HRDATA <= 32'h0000_0000;
      end
      else
      begin
         wr_pend_reg <= addr_ok && HWRITE && (HADDR[31:8] == 24'h00_0000);
         wr_addr_reg <= {HADDR[7:2], 2'b00};
         HREADYOUT <= 1'b1;
         HRESP <= 1'b0;
         HRDATA <= rd_ok ? {16'h0000, rd_val} : 32'h0000_0000;
      end
   end

   // Read decode, unmapped reads as zero
   always_comb
   begin
      logic [7:0] a;
      int k;
      k = 0;
      a = {HADDR[7:2], 2'b00};
      rd_val = 16'h0000;
      if (HADDR[31:8] == 24'h00_0000)
      begin
         for (k = 0; k < pic_pkg::NUM_FLAG_REGS; k++)
         begin
            if (a == pic_pkg::OFS_FLAGS0 + 8'(4 * k))
               rd_val = flags_reg[16*k +: 16];
            if (a == pic_pkg::OFS_ENABLE0 + 8'(4 * k))
               rd_val = enables_reg[16*k +: 16];
         end
         for (k = 0; k < NUM_SRC; k++)
            if (a == pic_pkg::OFS_PRIO0 + 8'(4 * (k / 4)))
               rd_val[pic_pkg::PRIO_FIELD_STRIDE*(k%4) +: 3] = prio_reg[k];
         if (a == pic_pkg::OFS_EXC_CTRL)
         begin
            rd_val[pic_pkg::NESTING_DISABLE_BIT] = nesting_disable_reg;
            rd_val[pic_pkg::NUM_TRAPS-1:0] = trap_reg;
         end
         if (a == pic_pkg::OFS_EXT_CTRL)
         begin
            rd_val[pic_pkg::ALT_TABLE_BIT] = alt_reg;
            rd_val[pic_pkg::TIMED_INTERRUPT_DISABLE_BIT] = (timed_interrupt_disable_reg != 14'h0000);
            rd_val[pic_pkg::NUM_EXT-1:0] = pol_reg;
         end
         if (a == pic_pkg::OFS_CPU_LEVEL)
            rd_val[3:0] = ipl_reg;
         if (a == pic_pkg::OFS_TIMED_INTERRUPT_DISABLE_CNT)
            rd_val[13:0] = timed_interrupt_disable_reg;
         if (a == pic_pkg::OFS_IRQ_STAT)
            rd_val = stat_reg;
         if (a == pic_pkg::OFS_IRQ_MASK)
            rd_val = mask_reg;
         if (a == pic_pkg::OFS_SERVICE)
            rd_val[7:0] = depth_reg;
      end
   end

   // External edge detection
   logic [pic_pkg::NUM_EXT-1:0] ext_evt;
   // Each pin has its own polarity: 1 selects the falling edge
   assign ext_evt = (pol_reg & ~EXT_REQ & ext_prev_reg)
                    | (~pol_reg & EXT_REQ & ~ext_prev_reg);

   always_ff @(posedge CLK_SYS or negedge RESET_N)
   begin
      if (!RESET_N)
         ext_prev_reg <= '0;
      else
         ext_prev_reg <= EXT_REQ;
   end

   // Request flags: set wins over a software write
   logic [FW-1:0] flag_set;
   logic [FW-1:0] flags_next;
   assign flag_set = FW'({PERIPH_REQ, ext_evt});

   always_comb
   begin
      int k;
      k = 0;
      flags_next = flags_reg;
      for (k = 0; k < pic_pkg::NUM_FLAG_REGS; k++)
         if (wr_en && wr_addr_reg == pic_pkg::OFS_FLAGS0 + 8'(4 * k))
            flags_next[16*k +: 16] = wd;
      flags_next = (flags_next | flag_set) & {{(FW-NUM_SRC){1'b0}}, {NUM_SRC{1'b1}}};
   end

   always_ff @(posedge CLK_SYS or negedge RESET_N)
   begin
      if (!RESET_N)
         flags_reg <= '0;
      else
         flags_reg <= flags_next;
   end

   // Enables and priority fields
   always_ff @(posedge CLK_SYS or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         enables_reg <= '0;
         for (int k = 0; k < NUM_SRC; k++)
            prio_reg[k] <= 3'h0;
      end
      else if (wr_en)
      begin
         for (int k = 0; k < pic_pkg::NUM_FLAG_REGS; k++)
            if (wr_addr_reg == pic_pkg::OFS_ENABLE0 + 8'(4 * k))
               enables_reg[16*k +: 16] <= wd;
         for (int k = 0; k < NUM_SRC; k++)
            if (wr_addr_reg == pic_pkg::OFS_PRIO0 + 8'(4 * (k / 4)))
               prio_reg[k] <= wd[pic_pkg::PRIO_FIELD_STRIDE*(k%4) +: 3];
      end
   end

   // Control registers
   always_ff @(posedge CLK_SYS or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         nesting_disable_reg <= 1'b0;
         alt_reg <= 1'b0;
         pol_reg <= '0;
         mask_reg <= pic_pkg::IRQ_MASK_RESET;
      end
      else if (wr_en)
      begin
         if (wr_addr_reg == pic_pkg::OFS_EXC_CTRL)
            nesting_disable_reg <= wd[pic_pkg::NESTING_DISABLE_BIT];
         if (wr_addr_reg == pic_pkg::OFS_EXT_CTRL)
         begin
            alt_reg <= wd[pic_pkg::ALT_TABLE_BIT];
            pol_reg <= wd[pic_pkg::NUM_EXT-1:0];
         end
         if (wr_addr_reg == pic_pkg::OFS_IRQ_MASK)
            mask_reg <= wd;
      end
   end

   // Address error on a vector-space fetch outside vectoring
   logic addr_err;
   assign addr_err = FETCH_VALID && !FETCH_VECTOR && (FETCH_ADDR <= pic_pkg::VECTOR_SPACE_END);

   // Trap flags, set wins over a write
   logic [pic_pkg::NUM_TRAPS-1:0] trap_next;

   always_comb
   begin
      trap_next = trap_reg;
      if (wr_en && wr_addr_reg == pic_pkg::OFS_EXC_CTRL)
         trap_next = wd[pic_pkg::NUM_TRAPS-1:0];
      trap_next = trap_next | TRAP_REQ;
      trap_next[1] = trap_next[1] | addr_err;
   end

   always_ff @(posedge CLK_SYS or negedge RESET_N)
   begin
      if (!RESET_N)
         trap_reg <= '0;
      else
         trap_reg <= trap_next;
   end

   // Arbitration
   logic found;
   logic [3:0] best_lvl;
   logic [5:0] best_vec;
   logic timed_interrupt_disable_on;
   assign timed_interrupt_disable_on = (timed_interrupt_disable_reg != 14'h0000);

   always_comb
   begin
      logic [3:0] lv;
      lv = 4'h0;
      found = 1'b0;
      best_lvl = 4'h0;
      best_vec = 6'h00;
      for (int i = 0; i < NUM_SRC; i++)
      begin
         lv = {1'b0, prio_reg[i]};
         if (flags_reg[i] && enables_reg[i] && lv != 4'h0
             && lv > ipl_reg && lv > best_lvl
             && !(timed_interrupt_disable_on && lv <= pic_pkg::TIMED_INTERRUPT_DISABLE_MAX_LEVEL))
         begin
            found = 1'b1;
            best_lvl = lv;
            best_vec = pic_pkg::IRQ_BASE_VECTOR + 6'(i);
         end
      end
      for (int t = 0; t < pic_pkg::NUM_TRAPS; t++)
      begin
         lv = pic_pkg::TRAP_BASE_LEVEL + 4'(t);
         if (trap_reg[t] && lv > ipl_reg && lv >= best_lvl)
         begin
            found = 1'b1;
            best_lvl = lv;
            best_vec = pic_pkg::TRAP_BASE_VECTOR + 6'(t);
         end
      end
      if (nesting_disable_reg && depth_reg != 8'h00)
         found = 1'b0;
   end

   // Request to the core and wake-up
   always_ff @(posedge CLK_SYS or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         CORE_REQ <= '0;
         WAKE <= 1'b0;
      end
      else
      begin
         CORE_REQ.valid <= found && !INT_ACK && !fetch_wait_reg;
         CORE_REQ.vector <= best_vec;
         CORE_REQ.level <= best_lvl;
         WAKE <= found && SLEEP_OR_IDLE;
      end
   end

   // CPU level, service depth
   always_ff @(posedge CLK_SYS or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         ipl_reg <= pic_pkg::CPU_LEVEL_RESET;
         depth_reg <= 8'h00;
      end
      else
      begin
         if (INT_ACK && CORE_REQ.valid)
         begin
            ipl_reg <= CORE_REQ.level;
            depth_reg <= depth_reg + 8'h01;
         end
         else if (INT_RET && depth_reg != 8'h00)
         begin
            ipl_reg <= RET_LEVEL;
            depth_reg <= depth_reg - 8'h01;
         end
         else if (wr_en && wr_addr_reg == pic_pkg::OFS_CPU_LEVEL && !nesting_disable_reg)
            ipl_reg <= wd[3:0];
      end
   end

   always_ff @(posedge CLK_SYS or negedge RESET_N)
   begin
      if (!RESET_N)
         CPU_LEVEL <= pic_pkg::CPU_LEVEL_RESET;
      else
         CPU_LEVEL <= ipl_reg;
   end

   // Timed disable counter
   always_ff @(posedge CLK_SYS or negedge RESET_N)
   begin
      if (!RESET_N)
         timed_interrupt_disable_reg <= 14'h0000;
      else if (TIMED_INTERRUPT_DISABLE_START)
         timed_interrupt_disable_reg <= TIMED_INTERRUPT_DISABLE_COUNT;
      else if (INSTR_DONE && timed_interrupt_disable_on)
         timed_interrupt_disable_reg <= timed_interrupt_disable_reg - 14'h0001;
   end

   // Vector fetch and program counter input multiplexer
   always_ff @(posedge CLK_SYS or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         fetch_wait_reg <= 1'b0;
         VEC_FETCH <= 1'b0;
         VEC_ADDR <= 24'h000000;
         PC_LOAD <= 1'b0;
         PC_VALUE <= 24'h000000;
      end
      else
      begin
         VEC_FETCH <= 1'b0;
         PC_LOAD <= 1'b0;
         if (INT_ACK && CORE_REQ.valid)
         begin
            fetch_wait_reg <= 1'b1;
            VEC_FETCH <= 1'b1;
            VEC_ADDR <= (alt_reg ? pic_pkg::ALTERNATE_TABLE_BASE
                                 : pic_pkg::PRIMARY_TABLE_BASE)
                        + {17'h00000, CORE_REQ.vector - 6'h01, 1'b0};
         end
         if (fetch_wait_reg && PDATA_VALID)
         begin
            fetch_wait_reg <= 1'b0;
            PC_LOAD <= 1'b1;
            PC_VALUE <= PDATA;
         end
         else
            PC_VALUE <= PC_SEQ;
      end
   end

   // Shadow copies
   always_ff @(posedge CLK_SYS or negedge RESET_N)
   begin
      if (!RESET_N)
         SHADOW_OUT <= '0;
      else if (SHADOW_PUSH)
         SHADOW_OUT <= SHADOW_IN;
   end

   // Block events: sticky, cleared by read, set wins
   logic [pic_pkg::NUM_EVT-1:0] evt;
   assign evt = {(timed_interrupt_disable_reg == 14'h0001) && INSTR_DONE && !TIMED_INTERRUPT_DISABLE_START,
                 addr_err, INT_ACK && CORE_REQ.valid};
   logic rclr;
   logic [15:0] stat_next;
   assign rclr = rd_ok && {HADDR[7:2], 2'b00} == pic_pkg::OFS_IRQ_STAT
                 && HADDR[31:8] == 24'h00_0000;
   assign stat_next = (rclr ? 16'h0000 : stat_reg) | 16'(evt);

   always_ff @(posedge CLK_SYS or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         stat_reg <= 16'h0000;
         IRQ <= 1'b0;
      end
      else
      begin
         stat_reg <= stat_next;
         IRQ <= |(stat_next & mask_reg);
      end
   end
endmodule : pic_top
`default_nettype wire

//--- testbench/pic_core_model.sv
// Core-side model: takes requests and answers vector word fetches
`timescale 1ns/100ps
`default_nettype none
module pic_core_model (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Bench control
   input wire logic auto_ack,
   input wire logic slow,
   // Request handshake
   input wire pic_pkg::pic_req_s core_req,
   output logic int_ack,
   // Vector word fetch
   input wire logic vec_fetch,
   input wire logic [23:0] vec_addr,
   output logic pdata_valid,
   output logic [23:0] pdata
);
   logic busy_reg;
   logic [2:0] wait_reg;
   logic [23:0] addr_reg;

   // One acknowledge per request, none while a vector fetch is open
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         int_ack <= 1'b0;
         busy_reg <= 1'b0;
      end
      else
      begin
         int_ack <= auto_ack && core_req.valid && !int_ack && !busy_reg;
         if (int_ack && core_req.valid)
            busy_reg <= 1'b1;
         else if (pdata_valid)
            busy_reg <= 1'b0;
      end
   end

   // Program bus shows a fresh pattern every cycle outside the answer
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wait_reg <= 3'h0;
         pdata_valid <= 1'b0;
         pdata <= 24'h0;
         addr_reg <= 24'h0;
      end
      else
      begin
         pdata_valid <= wait_reg == 3'h1;
         pdata <= (wait_reg == 3'h1) ? {8'h5a, addr_reg[15:0]} : ~pdata;
         if (vec_fetch)
         begin
            wait_reg <= slow ? 3'h5 : 3'h1;
            addr_reg <= vec_addr;
         end
         else if (wait_reg != 3'h0)
            wait_reg <= wait_reg - 3'h1;
      end
   end
endmodule : pic_core_model
`default_nettype wire

//--- testbench/pic_top_asserts.sv
// Concurrent checks on the core-side ports of the interrupt controller
`timescale 1ns/100ps
`default_nettype none
module pic_top_asserts (
   // Clock and reset
   input wire logic CLK_SYS,
   input wire logic RESET_N,
   // Core side
   input wire pic_pkg::pic_req_s CORE_REQ,
   input wire logic INT_ACK,
   input wire logic VEC_FETCH,
   input wire logic [23:0] VEC_ADDR,
   input wire logic PDATA_VALID,
   input wire logic [23:0] PDATA,
   input wire logic PC_LOAD,
   input wire logic [23:0] PC_VALUE,
   // Power and shadow
   input wire logic SLEEP_OR_IDLE,
   input wire logic WAKE,
   input wire logic SHADOW_PUSH,
   input wire pic_pkg::pic_shadow_s SHADOW_IN,
   input wire pic_pkg::pic_shadow_s SHADOW_OUT
);
   logic [23:0] voff_reg;
   default clocking cb @(posedge CLK_SYS);
   endclocking
   default disable iff (!RESET_N);

   // Table offset of the vector offered one cycle earlier
   always_ff @(posedge CLK_SYS)
   begin
      voff_reg <= {17'h0, CORE_REQ.vector, 1'b0} - 24'h2;
   end

   a_ack_fetch: assert property (
      INT_ACK && CORE_REQ.valid |=> VEC_FETCH ##1 !VEC_FETCH) else $error("no vector fetch");
   a_req_quiet: assert property (
      INT_ACK && CORE_REQ.valid |=> !CORE_REQ.valid [*2]) else $error("request not dropped");
   a_vec_addr: assert property (VEC_FETCH |->
      VEC_ADDR - voff_reg == pic_pkg::PRIMARY_TABLE_BASE
      || VEC_ADDR - voff_reg == pic_pkg::ALTERNATE_TABLE_BASE) else $error("bad vector address");
   a_pc_value: assert property (
      PC_LOAD |-> $past(PDATA_VALID) && PC_VALUE == $past(PDATA)) else $error("bad pc value");
   a_load_once: assert property (
      PDATA_VALID |=> PC_LOAD ##1 !PC_LOAD) else $error("pc load not one pulse");
   a_trap_level: assert property (
      CORE_REQ.valid && CORE_REQ.vector < pic_pkg::IRQ_BASE_VECTOR
      |-> CORE_REQ.level == 4'(CORE_REQ.vector) + 4'h7) else $error("bad trap level");
   a_src_level: assert property (
      CORE_REQ.valid && CORE_REQ.vector >= pic_pkg::IRQ_BASE_VECTOR
      |-> CORE_REQ.level inside {[4'h1:4'h7]}) else $error("bad source level");
   a_wake_req: assert property (
      $past(SLEEP_OR_IDLE) && SLEEP_OR_IDLE && CORE_REQ.valid |-> WAKE) else $error("no wake");
   a_shadow_cap: assert property (
      SHADOW_PUSH |=> SHADOW_OUT == $past(SHADOW_IN)) else $error("shadow not captured");
   a_shadow_hold: assert property (
      !SHADOW_PUSH |=> $stable(SHADOW_OUT)) else $error("shadow changed");

   c_ack: cover property (INT_ACK && CORE_REQ.valid);
   c_alt: cover property (VEC_FETCH && VEC_ADDR >= pic_pkg::ALTERNATE_TABLE_BASE);
   c_wake: cover property (WAKE);
endmodule : pic_top_asserts

bind pic_top pic_top_asserts chk (.*);
`default_nettype wire

//--- testbench/test_prioritized_interrupt_controller.sv
// Self-checking bench for the prioritized interrupt controller
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin errors++; \
   $display("mismatch %s exp %h got %h", n, e, g); end end
module test_prioritized_interrupt_controller;
   int errors = 0;
   int tests_run = 0;
   logic clk = 1'b0, rst_n = 1'b0, hwrite = 1'b0, int_ret = 1'b0, timed_interrupt_disable_go = 1'b0;
   logic instr_done = 1'b0, fvalid = 1'b0, sleep = 1'b0, spush = 1'b0, spop = 1'b0;
   logic auto_ack = 1'b0, slow = 1'b0, fvec = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [2:0] ext = 3'h0;
   logic [3:0] trap = 4'h0, ret_lvl = 4'h0, cpu_lvl;
   logic [13:0] timed_interrupt_disable_cnt = 14'h0;
   logic [23:0] faddr = 24'h0, vaddr, pdata, pc_val;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
   logic [37:0] preq = 38'h0;
   logic hready, hresp, irq, int_ack, vfetch, pdv, pc_load, wake;
   pic_pkg::pic_shadow_s sin = 69'h0, sout;
   pic_pkg::pic_req_s creq;

   pic_top #(.NUM_SRC(41)) uut (.CLK_SYS(clk), .RESET_N(rst_n), .HSEL(1'b1), .HADDR(haddr),
      .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready),
      .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp), .IRQ(irq), .EXT_REQ(ext),
      .PERIPH_REQ(preq), .TRAP_REQ(trap), .CORE_REQ(creq), .INT_ACK(int_ack),
      .INT_RET(int_ret), .RET_LEVEL(ret_lvl), .CPU_LEVEL(cpu_lvl), .TIMED_INTERRUPT_DISABLE_START(timed_interrupt_disable_go),
      .TIMED_INTERRUPT_DISABLE_COUNT(timed_interrupt_disable_cnt), .INSTR_DONE(instr_done), .VEC_FETCH(vfetch), .VEC_ADDR(vaddr),
      .PDATA_VALID(pdv), .PDATA(pdata), .PC_SEQ(24'h0), .PC_LOAD(pc_load),
      .PC_VALUE(pc_val), .FETCH_VALID(fvalid), .FETCH_VECTOR(fvec), .FETCH_ADDR(faddr),
      .SLEEP_OR_IDLE(sleep), .WAKE(wake), .SHADOW_PUSH(spush), .SHADOW_POP(spop),
      .SHADOW_IN(sin), .SHADOW_OUT(sout));

   pic_core_model core (.clk(clk), .rst_n(rst_n), .auto_ack(auto_ack), .slow(slow),
      .core_req(creq), .int_ack(int_ack), .vec_fetch(vfetch), .vec_addr(vaddr),
      .pdata_valid(pdv), .pdata(pdata));

   initial
   begin
      forever #12.5 clk = ~clk;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask : tick

   // One single word transfer; waits on ready in both phases
   task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d,
      output logic [31:0] r);
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      do @(posedge clk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= {16'h0, d};
      do @(posedge clk); while (hready !== 1'b1);
      r = hrdata;
   endtask : bus

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      logic [31:0] r;
      bus(1'b1, a, d, r);
   endtask : wr

   task automatic rchk(input string n, input logic [7:0] a, input logic [15:0] e);
      logic [31:0] r;
      bus(1'b0, a, 16'h0, r);
      `CHK(n, {16'h0, e}, r)
      `CHK("hresp", 1'b0, hresp)
   endtask : rchk

   task automatic wait_pc(input logic [23:0] e);
      int n;
      n = 0;
      while (pc_load !== 1'b1 && n < 60)
      begin
         @(posedge clk);
         n++;
      end
      `CHK("pc", {1'b1, e}, {pc_load, pc_val})
   endtask : wait_pc

   task automatic ret_to(input logic [3:0] l);
      ret_lvl <= l;
      int_ret <= 1'b1;
      tick(1);
      int_ret <= 1'b0;
   endtask : ret_to

   task automatic close_out;
      $display("errors %0d tests_run %0d", errors, tests_run);
      if (errors == 0 && tests_run > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : close_out

   initial
   begin
      #(25 * 5000);
      errors++;
      close_out();
   end

   initial
   begin
      tick(10);
      rst_n <= 1'b1;
      tick(1);
      rchk("cpu_lvl", 8'h58, {12'h0, pic_pkg::CPU_LEVEL_RESET});
      wr(8'h4c, 16'hffff);
      rchk("unmapped", 8'h4c, 16'h0000);
      wr(8'h20, 16'h2000);
      wr(8'h24, 16'h0005);
      preq <= 38'h7;
      tick(1);
      preq <= 38'h0;
      tick(2);
      rchk("flags", 8'h00, 16'h0038);
      `CHK("idle", 1'b0, creq.valid)
      wr(8'h0c, 16'h0038);
      tick(3);
      `CHK("req", {1'b1, 6'h0c, 4'h5}, creq)
      auto_ack <= 1'b1;
      wait_pc(24'h5a001a);
      auto_ack <= 1'b0;
      tick(2);
      `CHK("level", 5'h05, {creq.valid, cpu_lvl})
      wr(8'h50, 16'h8000);
      wr(8'h58, 16'h0000);
      rchk("lvl_ro", 8'h58, 16'h0005);
      wr(8'h24, 16'h0007);
      tick(3);
      `CHK("nest", 1'b0, creq.valid)
      wr(8'h00, 16'h0008);
      wr(8'h50, 16'h0000);
      ret_to(4'h0);
      tick(3);
      `CHK("ret", {1'b1, 6'h0b, 4'h2}, creq)
      wr(8'h64, 16'h0004);
      timed_interrupt_disable_cnt <= 14'h2;
      timed_interrupt_disable_go <= 1'b1;
      tick(1);
      timed_interrupt_disable_go <= 1'b0;
      tick(2);
      `CHK("timed_interrupt_disable", 2'b00, {creq.valid, irq})
      rchk("timed_interrupt_disable_bit", 8'h54, 16'h4000);
      repeat (2)
      begin
         instr_done <= 1'b1;
         tick(1);
         instr_done <= 1'b0;
         tick(1);
      end
      tick(2);
      `CHK("irq", 2'b11, {creq.valid, irq})
      rchk("status", 8'h60, 16'h0005);
      tick(2);
      `CHK("irq_clr", 1'b0, irq)
      sleep <= 1'b1;
      tick(3);
      `CHK("wake", 1'b1, wake)
      sleep <= 1'b0;
      wr(8'h54, 16'h8000);
      trap <= 4'h8;
      tick(1);
      trap <= 4'h0;
      tick(3);
      `CHK("trap", {1'b1, 6'h04, 4'hb}, creq)
      auto_ack <= 1'b1;
      slow <= 1'b1;
      wait_pc(24'h5a008a);
      auto_ack <= 1'b0;
      wr(8'h50, 16'h0000);
      ret_to(4'h0);
      faddr <= 24'h000100;
      fvalid <= 1'b1;
      tick(1);
      faddr <= 24'h000010;
      fvec <= 1'b1;
      tick(1);
      fvalid <= 1'b0;
      fvec <= 1'b0;
      tick(2);
      rchk("no_err", 8'h50, 16'h0000);
      faddr <= 24'h0000fe;
      fvalid <= 1'b1;
      tick(1);
      fvalid <= 1'b0;
      tick(2);
      rchk("addr_err", 8'h50, 16'h0002);
      wr(8'h54, 16'h0002);
      wr(8'h00, 16'h0000);
      ext <= 3'b011;
      tick(2);
      rchk("rise", 8'h00, 16'h0001);
      ext <= 3'b000;
      tick(2);
      rchk("fall", 8'h00, 16'h0003);
      sin <= {5'h15, 64'h0123456789abcdef};
      spush <= 1'b1;
      tick(1);
      spush <= 1'b0;
      sin <= 69'h0;
      spop <= 1'b1;
      tick(2);
      spop <= 1'b0;
      `CHK("shadow", {5'h15, 64'h0123456789abcdef}, sout)
      close_out();
   end
endmodule : test_prioritized_interrupt_controller
`default_nettype wire
